// [bench/tb_universal_shift_register.sv]
`timescale 1ns/1ps
// Self-checking bench: reference model against the register
module tb_universal_shift_register;
    import usr_pkg::*;
    localparam int FDEP = 16;
    // Stimulus; all but clk driven by non-blocking assignment, at edges or 1 ns after them
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic shclk = 1'b0;
    logic rsi = 1'b0;
    logic lsi = 1'b0;
    logic s_lo = 1'b0;
    logic s_hi = 1'b0;
    logic clr_n = 1'b1;
    logic en_a_n = 1'b0;
    logic en_b_n = 1'b0;
    logic [7:0] far_data = 8'h00;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    // Observed outputs
    logic [7:0] wire_lvl;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic tap0;
    logic tap7;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    // Model state and bookkeeping
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 64;
    int st = 0;
    int fq[$];
    bit cap = 1'b0;
    logic [31:0] rd;

    // Free-running reference clock, 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    usr_top dut (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(clk_en),
        .i_shift_clock_in(shclk), .i_right_shift_serial_in(rsi),
        .i_left_shift_serial_in(lsi), .i_op_select_lo(s_lo),
        .i_op_select_hi(s_hi), .i_async_clear_n(clr_n),
        .i_bus_drive_en_a_n(en_a_n), .i_bus_drive_en_b_n(en_b_n),
        .i_parallel_pins(wire_lvl), .o_parallel_pins(pin_out),
        .o_parallel_pins_oe(pin_oe), .o_first_stage_tap(tap0),
        .o_last_stage_tap(tap7), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp)
    );

    usr_far_side far (
        .i_clk(clk), .i_load_sel(s_hi & s_lo), .i_data(far_data),
        .i_dev_val(pin_out), .i_dev_oe(pin_oe), .o_wire(wire_lvl)
    );

    // Verdict and end of run
    task results;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // One comparison; four-state so unknowns never match
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait for hready sampled high at an edge
    task wait_ready;
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin
            bad_count++;
            results();
        end
    endtask : wait_ready

    // Single word transfer: address phase, then data phase
    task ahb(input bit wr, input logic [3:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {28'h0, a};
        hwrite <= wr;
        hsize <= USR_HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk(hresp, USR_HRESP_OKAY);
    endtask : ahb

    // Expected status word; full only checked at capacity
    function automatic int stat_exp();
        return st | ((fq.size() == 0) << 16) | ((fq.size() > FDEP) << 17)
            | (fq.size() << 24);
    endfunction : stat_exp

    // Stage word and both cascade taps against the model
    task see;
        chk(pin_out, st);
        chk(tap0, st & 1);
        chk(tap7, st >> 7);
    endtask : see

    // Model of one applied operation; snapshot when capturing
    task apply(input logic [1:0] m, input int sr, input int sl, input int pd);
        case (m)
            USR_SHR: st = ((st << 1) | sr) & 255;
            USR_SHL: st = (st >> 1) | (sl << 7);
            USR_LOAD: st = pd;
            default: st = st;
        endcase
        if (cap) begin
            fq.push_back(st);
        end
    endtask : apply

    // Set mode and enables, then one shift clock rise on the pin
    task do_op(input logic [1:0] m, input logic ea, input logic eb);
        logic [7:0] pd;
        pd = $random(seed);
        @(posedge clk);
        s_hi <= m[1];
        s_lo <= m[0];
        en_a_n <= ea;
        en_b_n <= eb;
        rsi <= $random(seed);
        lsi <= $random(seed);
        far_data <= pd;
        @(posedge clk);
        // Load waits a cycle so the pins are released first
        if (m == USR_LOAD) begin
            @(posedge clk);
        end
        shclk <= 1'b1;
        @(posedge clk);
        shclk <= 1'b0;
        // A full buffer holds the edge back
        if (clk_en && !(cap && fq.size() > FDEP)) begin
            apply(m, rsi, lsi, pd);
        end
        #1;
        see();
        chk(pin_oe, (ea | eb | (m == USR_LOAD)) ? 0 : 255);
    endtask : do_op

    // Main sequence
    initial begin
        repeat (9) @(posedge clk);
        #1;
        see();
        chk(pin_oe, 0);
        chk(hready, 1);
        @(posedge clk);
        rst_b <= 1'b1;
        ahb(1'b0, USR_OFF_CTRL, 0);
        chk(rd, 0);
        ahb(1'b1, USR_OFF_STATUS, 32'hffffffff);
        ahb(1'b0, USR_OFF_STATUS, 0);
        chk(rd, stat_exp());
        ahb(1'b0, 4'hc, 0);
        chk(rd, 0);
        // Every mode under every enable pairing
        for (int i = 0; i < 16; i++) begin
            do_op(i[1:0], i[2], i[3]);
        end
        repeat (20) begin
            do_op($random(seed), $random(seed), $random(seed));
        end
        // Frozen datapath ignores the shift clock
        do_op(USR_HOLD, 1'b0, 1'b0);
        @(posedge clk);
        clk_en <= 1'b0;
        do_op(USR_SHR, 1'b0, 1'b0);
        @(posedge clk);
        clk_en <= 1'b1;
        do_op(USR_LOAD, 1'b0, 1'b0);
        // Clear acts at once and overrides a clock rise
        @(posedge clk);
        clr_n <= 1'b0;
        #10;
        st = 0;
        see();
        @(posedge clk);
        shclk <= 1'b1;
        @(posedge clk);
        shclk <= 1'b0;
        @(posedge clk);
        clr_n <= 1'b1;
        #1;
        see();
        // Capture on: fill the buffer until it refuses
        ahb(1'b1, USR_OFF_CTRL, 1);
        cap = 1'b1;
        for (int i = 0; i <= FDEP; i++) begin
            do_op($random(seed), $random(seed), $random(seed));
        end
        ahb(1'b0, USR_OFF_STATUS, 0);
        chk(rd, stat_exp());
        do_op(USR_SHR, 1'b0, 1'b0);
        // One pop makes room; the held edge then lands
        ahb(1'b0, USR_OFF_DATA, 0);
        chk(rd, 32'h80000000 | fq.pop_front());
        apply(USR_SHR, rsi, 0, 0);
        // Held edge lands at this very edge; look once it settles
        #1;
        see();
        while (fq.size() > 0) begin
            ahb(1'b0, USR_OFF_DATA, 0);
            chk(rd, 32'h80000000 | fq.pop_front());
        end
        ahb(1'b0, USR_OFF_DATA, 0);
        chk(rd[31], 0);
        ahb(1'b0, USR_OFF_STATUS, 0);
        chk(rd, stat_exp());
        results();
    end
endmodule : tb_universal_shift_register

// [bench/usr_far_side.sv]
`timescale 1ns/1ps
// Far-side bus logic plus the resolved level of the shared pins
module usr_far_side (
    input wire logic i_clk,
    input wire logic i_load_sel,
    input wire logic [7:0] i_data,
    input wire logic [7:0] i_dev_val,
    input wire logic [7:0] i_dev_oe,
    output logic [7:0] o_wire
);
    // Last resolved level, used to spoil undriven pins
    logic [7:0] last_r = 8'h00;

    // Remember the wire so a floating pin never keeps its value
    always_ff @(posedge i_clk) begin
        last_r <= o_wire;
    end

    // Per pin: clash gives unknown, floating pins toggle each cycle
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (i_dev_oe[b] && i_load_sel) begin
                o_wire[b] = 1'bx;
            end else if (i_dev_oe[b]) begin
                o_wire[b] = i_dev_val[b];
            end else if (i_load_sel) begin
                o_wire[b] = i_data[b];
            end else begin
                o_wire[b] = ~last_r[b];
            end
        end
    end
endmodule : usr_far_side

// [pkg/usr_fifo_if.sv]
`timescale 1ns/1ps
// Snapshot path between the register core and its buffer
interface usr_fifo_if #(
    parameter int W = 8,
    parameter int LW = 5
);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    logic [LW-1:0] level;
    modport fifo (
        input wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data, level
    );
    modport user (
        output wr_valid, wr_data, rd_ready,
        input wr_ready, rd_valid, rd_data, level
    );
endinterface : usr_fifo_if

// [pkg/usr_pkg.sv]
// Contract
// - Eight D stages form one 8-bit register
// - Clear low forces all stages low immediately
// - State changes only on shift clock rise
// - Selects pick load, right or left shift
// - Right shift: serial into stage 0, upward
// - Left shift: serial into stage 7, downward
// - Load captures parallel pin levels into stages
// - Enabled buffers drive stage values onto pins
// - Either enable high releases all parallel pins
// - Load mode also releases the parallel pins
// - Operations continue while pins are released
// - First and last stages always on taps
package usr_pkg;
    // Register width and snapshot buffer depth
    localparam int USR_WIDTH = 8;
    localparam int USR_FIFO_DEPTH = 16;
    // Low address bits decoded; higher bits alias
    localparam int USR_AW = 4;
    localparam logic [3:0] USR_OFF_CTRL = 4'h0;
    localparam logic [3:0] USR_OFF_STATUS = 4'h4;
    localparam logic [3:0] USR_OFF_DATA = 4'h8;
    // Field positions
    localparam int USR_CTRL_CAP_BIT = 0;
    localparam int USR_STAT_EMPTY_BIT = 16;
    localparam int USR_STAT_FULL_BIT = 17;
    localparam int USR_STAT_LEVEL_LSB = 24;
    localparam int USR_DATA_VALID_BIT = 31;
    // Reset values
    localparam logic USR_CTRL_CAP_RST = 1'b0;
    localparam logic USR_SCLK_PREV_RST = 1'b1;
    // Bus constants
    localparam logic [2:0] USR_HSIZE_WORD = 3'h2;
    localparam logic USR_HRESP_OKAY = 1'b0;
    // Operation picked by {hi, lo} selects
    typedef enum logic [1:0] {
        USR_HOLD = 2'h0,
        USR_SHR = 2'h1,
        USR_SHL = 2'h2,
        USR_LOAD = 2'h3
    } usr_mode_e;
endpackage : usr_pkg

// [verilog/usr_fifo.sv]
`timescale 1ns/1ps
// Snapshot buffer; read word comes from an output register
module usr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    usr_fifo_if.fifo f
);
    // DEPTH must be a power of two so pointers wrap freely
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0] mem_r [DEPTH]; // Storage, no reset needed
    logic [AW-1:0] wp_r; // Write pointer
    logic [AW-1:0] rp_r; // Read pointer
    logic [AW:0] cnt_r; // Words in storage
    logic [W-1:0] out_r; // Head word register
    logic outv_r; // Head register holds a word
    logic push;
    logic refill;

    // Full means storage full; head register is extra slack
    assign f.wr_ready = (cnt_r != FULL_CNT);
    assign push = f.wr_valid & f.wr_ready;
    // Refill head when it is empty or being consumed
    assign refill = (cnt_r != '0) & (~outv_r | f.rd_ready);
    assign f.rd_valid = outv_r;
    assign f.rd_data = out_r;
    assign f.level = cnt_r + (AW+1)'(outv_r);

    // Storage write
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wp_r] <= f.wr_data;
        end
    end

    // Pointers and count
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (refill) begin
                rp_r <= rp_r + 1'b1;
            end
            unique case ({push, refill})
                2'b10: cnt_r <= cnt_r + 1'b1;
                2'b01: cnt_r <= cnt_r - 1'b1;
                default: cnt_r <= cnt_r;
            endcase
        end
    end

    // Head register; refill never reads a word written this cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_r <= '0;
            outv_r <= 1'b0;
        end else if (refill) begin
            out_r <= mem_r[rp_r];
            outv_r <= 1'b1;
        end else if (f.rd_ready) begin
            outv_r <= 1'b0;
        end
    end
endmodule : usr_fifo

// [verilog/usr_top.sv]
`timescale 1ns/1ps
// Universal shift and storage register with AHB-Lite snapshot port
module usr_top
    import usr_pkg::*;
#(
    parameter int WIDTH = USR_WIDTH,
    parameter int FIFO_DEPTH = USR_FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic i_shift_clock_in,
    input wire logic i_right_shift_serial_in,
    input wire logic i_left_shift_serial_in,
    input wire logic i_op_select_lo,
    input wire logic i_op_select_hi,
    input wire logic i_async_clear_n,
    input wire logic i_bus_drive_en_a_n,
    input wire logic i_bus_drive_en_b_n,
    input wire logic [WIDTH-1:0] i_parallel_pins,
    output logic [WIDTH-1:0] o_parallel_pins,
    output logic [WIDTH-1:0] o_parallel_pins_oe,
    output logic o_first_stage_tap,
    output logic o_last_stage_tap,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // Storage stages and their next value
    logic [WIDTH-1:0] stage_r;
    logic [WIDTH-1:0] stage_nxt;
    // Combined clear: system reset or clear pin
    logic clr_n;
    // Shift clock edge tracking
    logic sclk_prev_r; // Last sampled shift clock level
    logic pend_r; // Edge waiting for buffer room
    logic rise_now; // Low-to-high seen this cycle
    logic room; // Snapshot can be accepted
    logic go; // Apply one operation this cycle
    usr_mode_e mode; // Operation from the selects
    // Pin drive enable register
    logic [WIDTH-1:0] oe_r;
    // Software control
    logic cap_en_r; // Snapshots pushed into the buffer
    // Bus slave state
    logic ahb_take; // Address phase accepted
    logic wr_pend_r; // Write data phase in progress
    logic [USR_AW-1:0] wr_addr_r; // Address of that write
    logic [31:0] hrdata_r; // Read data register
    logic [31:0] rd_mux; // Read value for the accepted address
    logic hreadyout_r;
    logic hresp_r;
    logic [USR_AW-1:0] addr_lo; // Decoded address bits

    usr_fifo_if #(.W(WIDTH), .LW(LW)) fifo_if ();

    // Snapshot buffer
    usr_fifo #(
        .W(WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .f(fifo_if.fifo)
    );

    // Edge detect on the sampled shift clock pin
    assign rise_now = i_shift_clock_in & ~sclk_prev_r;
    // A full buffer stalls the register instead of losing a snapshot
    assign room = ~cap_en_r | fifo_if.wr_ready;
    // Only a clock rise, gated by the clock enable and held back by back-pressure
    assign go = i_clk_en & (rise_now | pend_r) & room;
    assign mode = usr_mode_e'({i_op_select_hi, i_op_select_lo});

    // Edge tracker; reset high so a pin already high is no edge
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_prev_r <= USR_SCLK_PREV_RST;
            pend_r <= 1'b0;
        end else if (i_clk_en) begin
            sclk_prev_r <= i_shift_clock_in;
            pend_r <= (rise_now | pend_r) & ~room;
        end
    end

    // Steering logic between the stages
    always_comb begin
        stage_nxt = stage_r;
        unique case (mode)
            // Keep contents
            USR_HOLD: stage_nxt = stage_r;
            // Serial in at stage 0, each stage moves up
            USR_SHR: begin
                stage_nxt = {stage_r[WIDTH-2:0], i_right_shift_serial_in};
            end
            // Serial in at top stage, each stage moves down
            USR_SHL: begin
                stage_nxt = {i_left_shift_serial_in, stage_r[WIDTH-1:1]};
            end
            // Pins are released here; far side supplies the word
            USR_LOAD: stage_nxt = i_parallel_pins;
        endcase
    end

    // Clear overrides clock and selects at once
    assign clr_n = i_rst_b & i_async_clear_n;

    // Eight storage stages, one register
    always_ff @(posedge i_ref_clk or negedge clr_n) begin
        if (!clr_n) begin
            stage_r <= '0;
        end else if (go) begin
            stage_r <= stage_nxt;
        end
    end

    // Stage values on the pins; enables and load select decide the drive
    assign o_parallel_pins = stage_r;
    // Taps never depend on the drive enables
    assign o_first_stage_tap = stage_r[0];
    assign o_last_stage_tap = stage_r[WIDTH-1];
    assign o_parallel_pins_oe = oe_r;

    // Drive enable; registered, so it trails the inputs by a cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            oe_r <= '0;
        end else if (i_clk_en) begin
            // Either enable high or load selected releases the pins
            oe_r <= {WIDTH{~(i_bus_drive_en_a_n | i_bus_drive_en_b_n |
                (i_op_select_hi & i_op_select_lo))}};
        end
    end

    // Snapshot of every applied operation when capture is on
    assign fifo_if.wr_valid = go & cap_en_r;
    assign fifo_if.wr_data = stage_nxt;

    // Bus address phase: only whole-word transfers are acted on
    assign addr_lo = i_haddr[USR_AW-1:0];
    assign ahb_take = i_hsel & i_htrans[1] & i_hready &
        (i_hsize == USR_HSIZE_WORD);
    // Reading the data word pops the buffer head
    assign fifo_if.rd_ready = ahb_take & ~i_hwrite &
        (addr_lo == USR_OFF_DATA);

    // Read value, built at the address phase
    always_comb begin
        rd_mux = '0;
        unique case (addr_lo)
            USR_OFF_CTRL: rd_mux[USR_CTRL_CAP_BIT] = cap_en_r;
            USR_OFF_STATUS: begin
                rd_mux[WIDTH-1:0] = stage_r;
                rd_mux[USR_STAT_EMPTY_BIT] = ~fifo_if.rd_valid;
                rd_mux[USR_STAT_FULL_BIT] = ~fifo_if.wr_ready;
                rd_mux[USR_STAT_LEVEL_LSB +: LW] = fifo_if.level;
            end
            USR_OFF_DATA: begin
                rd_mux[WIDTH-1:0] = fifo_if.rd_data;
                rd_mux[USR_DATA_VALID_BIT] = fifo_if.rd_valid;
            end
            // Unmapped offsets read as zero
            default: rd_mux = '0;
        endcase
    end

    // Bus slave; never waits, always OKAY
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            hrdata_r <= '0;
            hreadyout_r <= 1'b1;
            hresp_r <= USR_HRESP_OKAY;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= USR_HRESP_OKAY;
            wr_pend_r <= ahb_take & i_hwrite;
            wr_addr_r <= addr_lo;
            if (ahb_take & ~i_hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // Control register; write lands in the data phase
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cap_en_r <= USR_CTRL_CAP_RST;
        end else if (wr_pend_r && wr_addr_r == USR_OFF_CTRL) begin
            cap_en_r <= i_hwdata[USR_CTRL_CAP_BIT];
        end
    end

    assign o_hrdata = hrdata_r;
    assign o_hreadyout = hreadyout_r;
    assign o_hresp = hresp_r;

    // Clear low holds every stage at zero
    property p_clear_low;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !i_async_clear_n |-> stage_r == '0;
    endproperty
    a_clear_low: assert property (p_clear_low)
        else $error("Stages not zero while clear is low");

    // No operation applied means no change
    property p_no_edge_no_change;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !go ##1 i_async_clear_n |-> $stable(stage_r);
    endproperty
    a_no_edge_no_change: assert property (p_no_edge_no_change)
        else $error("Stages changed without a shift clock rise");

    // Back-pressure keeps the edge pending, not lost
    property p_edge_pends;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_clk_en && rise_now && cap_en_r && !fifo_if.wr_ready
            |=> pend_r;
    endproperty
    a_edge_pends: assert property (p_edge_pends)
        else $error("Stalled edge was dropped");

    // Hold keeps the stored word
    property p_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go && mode == USR_HOLD ##1 i_async_clear_n |-> $stable(stage_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Hold changed the stages");

    // Right shift moves up with serial in at stage 0
    property p_shift_right;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go && mode == USR_SHR ##1 i_async_clear_n |->
            stage_r == {$past(stage_r[WIDTH-2:0]),
                        $past(i_right_shift_serial_in)};
    endproperty
    a_shift_right: assert property (p_shift_right)
        else $error("Right shift result wrong");

    // Left shift moves down with serial in at the top
    property p_shift_left;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go && mode == USR_SHL ##1 i_async_clear_n |->
            stage_r == {$past(i_left_shift_serial_in),
                        $past(stage_r[WIDTH-1:1])};
    endproperty
    a_shift_left: assert property (p_shift_left)
        else $error("Left shift result wrong");

    // Load takes the pin levels
    property p_load;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go && mode == USR_LOAD ##1 i_async_clear_n |->
            stage_r == $past(i_parallel_pins);
    endproperty
    a_load: assert property (p_load)
        else $error("Parallel load captured wrong word");

    // Either enable high releases the pins next cycle
    property p_oe_off;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_clk_en && (i_bus_drive_en_a_n || i_bus_drive_en_b_n)
            |=> o_parallel_pins_oe == '0;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("Pins driven with an enable high");

    // Load select releases the pins next cycle
    property p_oe_load;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_clk_en && i_op_select_hi && i_op_select_lo
            |=> o_parallel_pins_oe == '0;
    endproperty
    a_oe_load: assert property (p_oe_load)
        else $error("Pins driven in load mode");

    // Both enables low and no load: all pins driven
    property p_oe_on;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_clk_en && !i_bus_drive_en_a_n && !i_bus_drive_en_b_n &&
            !(i_op_select_hi && i_op_select_lo)
            |=> o_parallel_pins_oe == '1;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("Pins not driven while enabled");

    // Last tap follows a right shift even with pins released
    property p_tap_follows;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go && mode == USR_SHR ##1 i_async_clear_n |->
            o_last_stage_tap == $past(stage_r[WIDTH-2]);
    endproperty
    a_tap_follows: assert property (p_tap_follows)
        else $error("Last tap did not follow the shift");

    // Right-shift select puts serial in at stage 0
    property p_sel_right;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go && !i_op_select_hi && i_op_select_lo ##1 i_async_clear_n
            |-> stage_r[0] == $past(i_right_shift_serial_in);
    endproperty
    a_sel_right: assert property (p_sel_right)
        else $error("Select decode missed right shift");

    // Left-shift select puts serial in at the top stage
    property p_sel_left;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go && i_op_select_hi && !i_op_select_lo ##1 i_async_clear_n
            |-> stage_r[WIDTH-1] == $past(i_left_shift_serial_in);
    endproperty
    a_sel_left: assert property (p_sel_left)
        else $error("Select decode missed left shift");

    // First tap follows a left shift whatever the enables
    property p_first_tap;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go && mode == USR_SHL ##1 i_async_clear_n |->
            o_first_stage_tap == $past(stage_r[1]);
    endproperty
    a_first_tap: assert property (p_first_tap)
        else $error("First tap did not follow the shift");

    // An applied edge leaves nothing pending behind it,
    // so one pin rise never acts twice
    property p_pend_done;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        go |=> !pend_r;
    endproperty
    a_pend_done: assert property (p_pend_done)
        else $error("Applied edge stayed pending");
endmodule : usr_top
